// file: include/bldm_pkg.sv
package bldm_pkg;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [3:0] BLDM_IDX_CMD = 4'h0;
  localparam logic [3:0] BLDM_IDX_CTRL1 = 4'h1;
  localparam logic [3:0] BLDM_IDX_AXIS = 4'h2;
  localparam logic [3:0] BLDM_IDX_ERR = 4'h3;
  localparam logic [3:0] BLDM_IDX_DEST_LO = 4'h4;
  localparam logic [3:0] BLDM_IDX_DEST_HI = 4'h5;
  localparam logic [3:0] BLDM_IDX_DIMX = 4'h6;
  localparam logic [3:0] BLDM_IDX_DIMY = 4'h7;
  localparam logic [3:0] BLDM_IDX_PITCH = 4'h8;
  localparam logic [3:0] BLDM_IDX_COLOR = 4'ha;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BLDM_CMD_START = 0;
  localparam int BLDM_CMD_HICOL = 1;
  localparam int BLDM_C1_LINE = 11;
  localparam int BLDM_C1_YMAJOR = 9;
  localparam int BLDM_C1_YUP = 8;
  localparam int BLDM_STEP_W = 10;
  localparam int BLDM_ADDR_W = 21;
  localparam int BLDM_PITCH_SHIFT = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] BLDM_RST_REG16 = 16'h0000;
  localparam logic [9:0] BLDM_RST_STEP = 10'h000;
  localparam logic [4:0] BLDM_RST_DEST_HI = 5'h00;
  localparam logic [31:0] BLDM_RST_PRDATA = 32'h0000_0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [0:0] {
    BLDM_IDLE,
    BLDM_RUN
  } bldm_state_e;

  // Display memory write request
  typedef struct packed {
    logic [BLDM_ADDR_W-1:0] addr;
    logic [15:0] data;
    logic [1:0] be;
    logic [5:0] pat_idx;
  } bldm_mem_req_s;

  // All state of the engine
  typedef struct packed {
    bldm_state_e state;
    logic hicol;
    logic line_en;
    logic ymajor;
    logic yup;
    logic [9:0] axis_step;
    logic [9:0] err_step;
    logic [15:0] dest_lo;
    logic [4:0] dest_hi;
    logic [15:0] dimx;
    logic [15:0] dimy;
    logic [15:0] pitch;
    logic [15:0] color;
    logic [31:0] prdata;
    logic pslverr;
    logic [9:0] err;
    logic [15:0] cnt;
    logic [15:0] ycnt;
    logic [2:0] prow;
    logic [BLDM_ADDR_W-1:0] row_start;
    logic mem_valid;
    bldm_mem_req_s mem;
  } bldm_st_s;

endpackage : bldm_pkg

// file: verilog/bldm_err_step.sv
`timescale 1ns/1ps

// ****************************************
// Error accumulator step
// ****************************************
module bldm_err_step #(
  parameter int W = 10
) (
  input wire logic [W-1:0] err_in,
  input wire logic [W-1:0] step,
  output logic [W-1:0] err_out,
  output logic ovf
);

  logic [W:0] sum;

  // Carry out of the accumulator means a minor-axis move
  always_comb begin
    sum = {1'b0, err_in} + {1'b0, step};
    err_out = sum[W-1:0];
    ovf = sum[W];
  end

endmodule : bldm_err_step

// file: verilog/bldm_engine.sv
`timescale 1ns/1ps

// How it works
// [R1] Control bit 11 selects line draw
// [R2] Bit 9 major axis, bit 8 direction
// [R3] Axis step and error step registers
// [R4] Dimension registers give line extents
// [R5] Lines always drawn left to right
// [R6] Software loads rest as rectangle fill
// [R7] Software clears line bit afterwards
// [R8] One contiguous area, no interleave
// [R9] Text copies planar, font maps masked
// [R10] Character copies use eight-fold values
// [R11] High colour packed, doubled widths, pitch
// [R12] High colour right-to-left uses second byte
// [R13] High colour pattern repeats four by eight
// [R14] One pixel per major step, error carry
module bldm_engine
  import bldm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_valid,
  input wire logic mem_ready,
  output bldm_mem_req_s mem_req,
  output logic busy
);

  // ****************************************
  // State and helpers
  // ****************************************
  bldm_st_s st_reg;
  bldm_st_s st_next;
  logic [3:0] idx;
  logic mapped;
  logic [31:0] rd_val;
  logic [9:0] err_nx;
  logic err_ovf;
  logic [BLDM_ADDR_W-1:0] dest;
  logic [BLDM_ADDR_W-1:0] pitch_b;
  logic [BLDM_ADDR_W-1:0] bpp;
  logic [15:0] major_ext;
  logic last_major;
  logic last_col;
  logic last_row;
  logic [BLDM_ADDR_W-1:0] vstep;
  logic [BLDM_ADDR_W-1:0] addr_nx;
  logic vmove;
  logic fire;

  assign idx = paddr[5:2];
  assign pready = psel & penable;
  assign prdata = st_reg.prdata;
  assign pslverr = st_reg.pslverr & pready;
  assign mem_valid = st_reg.mem_valid;
  assign mem_req = st_reg.mem;
  assign busy = (st_reg.state == BLDM_RUN);
  assign dest = {st_reg.dest_hi, st_reg.dest_lo};
  // Pitch register holds eight times the byte distance between rows
  assign pitch_b = BLDM_ADDR_W'({st_reg.pitch >> BLDM_PITCH_SHIFT});
  // A high-colour pixel spans two packed bytes
  assign bpp = st_reg.hicol ? BLDM_ADDR_W'(2) : BLDM_ADDR_W'(1);
  assign fire = st_reg.mem_valid & mem_ready;

  // [R14] error carry step
  bldm_err_step #(
    .W(BLDM_STEP_W)
  ) u_err (
    .err_in(st_reg.err),
    .step(st_reg.err_step),
    .err_out(err_nx),
    .ovf(err_ovf)
  );

  // ****************************************
  // Register read decode
  // ****************************************
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (idx)
      BLDM_IDX_CMD: begin
        rd_val[BLDM_CMD_START] = busy;
        rd_val[BLDM_CMD_HICOL] = st_reg.hicol;
      end
      // [R1] line bit readback
      BLDM_IDX_CTRL1: begin
        rd_val[BLDM_C1_LINE] = st_reg.line_en;
        rd_val[BLDM_C1_YMAJOR] = st_reg.ymajor;
        rd_val[BLDM_C1_YUP] = st_reg.yup;
      end
      BLDM_IDX_AXIS: rd_val[9:0] = st_reg.axis_step;
      BLDM_IDX_ERR: rd_val[9:0] = st_reg.err_step;
      BLDM_IDX_DEST_LO: rd_val[15:0] = st_reg.dest_lo;
      BLDM_IDX_DEST_HI: rd_val[4:0] = st_reg.dest_hi;
      BLDM_IDX_DIMX: rd_val[15:0] = st_reg.dimx;
      BLDM_IDX_DIMY: rd_val[15:0] = st_reg.dimy;
      BLDM_IDX_PITCH: rd_val[15:0] = st_reg.pitch;
      BLDM_IDX_COLOR: rd_val[15:0] = st_reg.color;
      default: mapped = 1'b0;
    endcase
    if (paddr[31:6] != 26'h0 || paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
      rd_val = 32'h0000_0000;
    end
  end

  // ****************************************
  // Walk step decisions
  // ****************************************
  always_comb begin
    // [R4] extent along the dominant axis
    major_ext = st_reg.ymajor ? st_reg.dimy : st_reg.dimx;
    last_major = ({1'b0, st_reg.cnt} + 17'h1) >= {1'b0, major_ext};
    // Fill width counts bytes, so a high-colour pixel uses two of it
    last_col = ({1'b0, st_reg.cnt} + (st_reg.hicol ? 17'h2 : 17'h1)) >= {1'b0, st_reg.dimx};
    last_row = ({1'b0, st_reg.ycnt} + 17'h1) >= {1'b0, st_reg.dimy};
    // [R2] vertical direction sets sign of the row step
    vstep = st_reg.yup ? (BLDM_ADDR_W'(0) - pitch_b) : pitch_b;
    // [R14] major axis always moves, minor on carry
    vmove = st_reg.ymajor ? 1'b1 : err_ovf;
    addr_nx = st_reg.mem.addr;
    if (st_reg.ymajor) begin
      addr_nx = addr_nx + vstep;
      // [R5] minor moves only rightwards
      if (err_ovf) begin
        addr_nx = addr_nx + bpp;
      end
    end else begin
      addr_nx = addr_nx + bpp;
      if (err_ovf) begin
        addr_nx = addr_nx + vstep;
      end
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    // Setup phase captures read data so it comes from a flop
    if (psel && !penable) begin
      st_next.prdata = (!pwrite && mapped) ? rd_val : BLDM_RST_PRDATA;
      st_next.pslverr = !mapped;
    end
    // Register writes; parameters may change mid-walk, software must not
    if (pready && pwrite && mapped) begin
      case (idx)
        BLDM_IDX_CMD: st_next.hicol = pwdata[BLDM_CMD_HICOL];
        // [R1] line select bit, cleared only by a software write or reset
        BLDM_IDX_CTRL1: begin
          st_next.line_en = pwdata[BLDM_C1_LINE];
          // [R2] axis and direction bits
          st_next.ymajor = pwdata[BLDM_C1_YMAJOR];
          st_next.yup = pwdata[BLDM_C1_YUP];
        end
        // [R3] step values, ten bits each
        BLDM_IDX_AXIS: st_next.axis_step = pwdata[9:0];
        BLDM_IDX_ERR: st_next.err_step = pwdata[9:0];
        BLDM_IDX_DEST_LO: st_next.dest_lo = pwdata[15:0];
        BLDM_IDX_DEST_HI: st_next.dest_hi = pwdata[4:0];
        BLDM_IDX_DIMX: st_next.dimx = pwdata[15:0];
        BLDM_IDX_DIMY: st_next.dimy = pwdata[15:0];
        BLDM_IDX_PITCH: st_next.pitch = pwdata[15:0];
        BLDM_IDX_COLOR: st_next.color = pwdata[15:0];
        default: st_next.color = st_reg.color;
      endcase
    end
    case (st_reg.state)
      BLDM_IDLE: begin
        // Start ignored while running; a start write launches first pixel
        if (pready && pwrite && mapped && idx == BLDM_IDX_CMD && pwdata[BLDM_CMD_START]) begin
          st_next.state = BLDM_RUN;
          st_next.hicol = pwdata[BLDM_CMD_HICOL];
          // [R3] axis step seeds the error term
          st_next.err = st_reg.axis_step;
          st_next.cnt = 16'h0000;
          st_next.ycnt = 16'h0000;
          st_next.prow = 3'h0;
          // [R8] linear start address, no scan-line interleave
          st_next.row_start = dest;
          st_next.mem.addr = dest;
          st_next.mem_valid = 1'b1;
        end
      end
      BLDM_RUN: begin
        if (fire) begin
          if (st_reg.line_en) begin
            // [R1] line walk
            if (last_major) begin
              st_next.state = BLDM_IDLE;
              st_next.mem_valid = 1'b0;
            end else begin
              st_next.cnt = st_reg.cnt + 16'h1;
              st_next.err = err_nx;
              st_next.mem.addr = addr_nx;
              if (vmove) begin
                st_next.prow = st_reg.prow + 3'h1;
              end
            end
          end else if (!last_col) begin
            // Solid fill along the row
            st_next.cnt = st_reg.cnt + (st_reg.hicol ? 16'h2 : 16'h1);
            st_next.mem.addr = st_reg.mem.addr + bpp;
          end else if (!last_row) begin
            // [R8] next row is one pitch further, contiguous
            st_next.cnt = 16'h0000;
            st_next.ycnt = st_reg.ycnt + 16'h1;
            st_next.prow = st_reg.prow + 3'h1;
            st_next.row_start = st_reg.row_start + pitch_b;
            st_next.mem.addr = st_reg.row_start + pitch_b;
          end else begin
            st_next.state = BLDM_IDLE;
            st_next.mem_valid = 1'b0;
          end
        end
      end
      default: st_next.state = BLDM_IDLE;
    endcase
    // Next-state mode, so the first pixel after a start write is already right
    st_next.mem.data = st_next.hicol ? st_next.color : {2{st_next.color[7:0]}};
    st_next.mem.be = st_next.hicol ? 2'b11 : 2'b01;
    // [R13] paired bytes leave only four pattern columns
    st_next.mem.pat_idx = st_next.hicol ? {st_next.prow, st_next.mem.addr[2:1], 1'b0}
                                       : {st_next.prow, st_next.mem.addr[2:0]};
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.state <= BLDM_IDLE;
      st_reg.axis_step <= BLDM_RST_STEP;
      st_reg.err_step <= BLDM_RST_STEP;
      st_reg.dest_lo <= BLDM_RST_REG16;
      st_reg.dest_hi <= BLDM_RST_DEST_HI;
      st_reg.dimx <= BLDM_RST_REG16;
      st_reg.dimy <= BLDM_RST_REG16;
      st_reg.pitch <= BLDM_RST_REG16;
      st_reg.color <= BLDM_RST_REG16;
      st_reg.prdata <= BLDM_RST_PRDATA;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : bldm_engine

// file: tb/bldm_engine_asserts.sv
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module bldm_engine_asserts
  import bldm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire bldm_mem_req_s mem_req,
  input wire logic busy
);
  logic [15:0] c1_reg;
  logic [15:0] pit_reg;
  logic hc_reg;
  logic [20:0] row;
  logic [20:0] bpp;
  logic wr;
  logic bad;
  // Steps derived from shadowed setup
  assign wr = psel && penable && pwrite;
  assign bad = paddr[5:2] == 4'h9 || paddr[5:2] > 4'ha || paddr[31:6] != '0 || paddr[1:0] != '0;
  assign row = c1_reg[8] ? -21'(pit_reg[15:3]) : 21'(pit_reg[15:3]);
  assign bpp = hc_reg ? 21'h2 : 21'h1;
  // Shadow of setup, the engine keeps it internal
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      c1_reg <= '0;
      pit_reg <= '0;
      hc_reg <= 1'b0;
    end else if (wr) begin
      if (paddr[5:2] == BLDM_IDX_CTRL1) c1_reg <= pwdata[15:0];
      if (paddr[5:2] == BLDM_IDX_PITCH) pit_reg <= pwdata[15:0];
      if (paddr[5:2] == BLDM_IDX_CMD) hc_reg <= pwdata[BLDM_CMD_HICOL];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_pready_comb: assert property (pready == (psel && penable)) else $error("pready wrong");
  a_bad_addr: assert property (psel && !penable |=> pslverr == $past(bad))
    else $error("pslverr wrong");
  a_start_walk: assert property (wr && paddr[5:2] == BLDM_IDX_CMD && pwdata[0] && !busy
    |=> busy && mem_valid) else $error("walk did not start");
  a_req_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_req.addr))
    else $error("request dropped");
  a_idle_quiet: assert property (!busy |-> !mem_valid) else $error("write while idle");
  a_walk_end: assert property ($fell(busy) |-> $past(mem_valid && mem_ready))
    else $error("walk ended early");
  a_xmajor_step: assert property (c1_reg[11] && !c1_reg[9] && mem_valid && mem_ready ##1 mem_valid
    |-> mem_req.addr - $past(mem_req.addr) inside {bpp, bpp + row})
    else $error("x-major step wrong");
  a_ymajor_step: assert property (c1_reg[11] && c1_reg[9] && mem_valid && mem_ready ##1 mem_valid
    |-> mem_req.addr - $past(mem_req.addr) inside {row, bpp + row})
    else $error("y-major step wrong");
  a_byte_lanes: assert property (mem_valid |-> mem_req.be == (hc_reg ? 2'h3 : 2'h1))
    else $error("byte enables wrong");
  a_hc_pattern: assert property (mem_valid && hc_reg
    |-> mem_req.pat_idx[2:0] == {mem_req.addr[2:1], 1'b0}) else $error("pattern column wrong");
endmodule : bldm_engine_asserts

bind bldm_engine bldm_engine_asserts i_chk (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_req(mem_req), .busy(busy)
);

// file: tb/bldm_engine_tb_top.sv
`timescale 1ns/1ps
module bldm_engine_tb_top
  import bldm_pkg::*;
;
  logic sys_clk, rst, psel, penable, pwrite, mem_ready, pready, pslverr, mem_valid, busy, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  bldm_mem_req_s mem_req;
  logic [20:0] got[$];
  logic [15:0] gd[$];
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [3:0] ix[5] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h7};
  logic [31:0] mk[5] = '{32'hb00, 32'h3ff, 32'h3ff, 32'hffff, 32'hffff};

  bldm_engine i_dut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_req(mem_req), .busy(busy)
  );

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Memory stalls one cycle in four, so requests must hold
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    mem_ready <= cyc[1:0] != 2'h3;
    if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
      got.push_back(mem_req.addr);
      gd.push_back(mem_req.data);
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk

  task end_of_test;
    $display("checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // One APB transfer, idle cycle first so strobes never toggle twice at an edge
  task apb(input logic w, input logic [3:0] idx, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {26'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Set up, start, wait, then compare every pixel address with the model
  task run(input logic [15:0] c1, input logic hc, input logic [15:0] dx, input logic [15:0] dy,
           input logic [9:0] ax, input logic [9:0] es, input logic [20:0] d,
           input logic [15:0] pt);
    int n, k, col, i;
    logic [20:0] a, rs, row, bp;
    logic [10:0] s;
    logic [9:0] e;
    apb(1'b1, BLDM_IDX_DEST_LO, {16'h0, d[15:0]});
    apb(1'b1, BLDM_IDX_DEST_HI, {27'h0, d[20:16]});
    apb(1'b1, BLDM_IDX_PITCH, {16'h0, pt});
    apb(1'b1, BLDM_IDX_COLOR, 32'h9c3e);
    apb(1'b1, BLDM_IDX_DIMX, {16'h0, dx});
    apb(1'b1, BLDM_IDX_DIMY, {16'h0, dy});
    apb(1'b1, BLDM_IDX_AXIS, {22'h0, ax});
    apb(1'b1, BLDM_IDX_ERR, {22'h0, es});
    apb(1'b1, BLDM_IDX_CTRL1, {16'h0, c1});
    apb(1'b1, BLDM_IDX_CMD, {30'h0, hc, 1'b1});
    @(posedge sys_clk);
    i = 0;
    while (busy !== 1'b0 && i < 400) begin
      @(posedge sys_clk);
      i++;
    end
    chk(busy, 0);
    // Fill width counts bytes, a high-colour pixel takes two of them
    n = c1[11] ? (c1[9] ? dy : dx) : ((dx + hc) >> hc) * dy;
    if (n == 0) n = 1;
    row = c1[8] ? -21'(pt >> BLDM_PITCH_SHIFT) : 21'(pt >> BLDM_PITCH_SHIFT);
    bp = hc ? 21'h2 : 21'h1;
    a = d;
    rs = a;
    e = ax;
    col = 0;
    chk(got.size(), n);
    for (k = 0; k < n; k++) begin
      chk(got[k], a);
      chk(gd[k], hc ? 32'h9c3e : 32'h3e3e);
      s = e + es;
      e = s[9:0];
      col = col + (hc ? 2 : 1);
      if (c1[11] && !c1[9]) a = a + bp + (s[10] ? row : 21'h0);
      else if (c1[11]) a = a + row + (s[10] ? bp : 21'h0);
      else if (col >= dx) begin
        rs = rs + row;
        a = rs;
        col = 0;
      end else a = a + bp;
    end
    got.delete();
    gd.delete();
  endtask : run

  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    mem_ready = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int j = 0; j < 5; j++) begin
      apb(1'b0, ix[j], 32'h0);
      chk(rd, 0);
      apb(1'b1, ix[j], 32'hffff_ffff);
      apb(1'b0, ix[j], 32'h0);
      chk(rd, mk[j]);
    end
    apb(1'b0, 4'h9, 32'h0);
    chk(er, 1);
    apb(1'b0, BLDM_IDX_DIMX, 32'h0);
    chk(er, 0);
    run(16'h0800, 1'b0, 16'h3, 16'h1, 10'h0, 10'h200, 21'h12345, 16'h50);
    run(16'h0b00, 1'b1, 16'h2, 16'h5, 10'h100, 10'h180, 21'h12345, 16'h50);
    run(16'h0900, 1'b0, 16'h4, 16'h2, 10'h3ff, 10'h1, 21'h12345, 16'h50);
    run(16'h0a00, 1'b1, 16'h5, 16'h0, 10'h0, 10'h3, 21'h12345, 16'h50);
    run(16'h0000, 1'b0, 16'h2, 16'h3, 10'h0, 10'h0, 21'h12345, 16'h50);
    run(16'h0000, 1'b0, 16'h10, 16'h2, 10'h0, 10'h0, 21'h12340, 16'h280);
    run(16'h0000, 1'b1, 16'h6, 16'h2, 10'h0, 10'h0, 21'h12344, 16'h50);
    end_of_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end
endmodule : bldm_engine_tb_top
